// [supervisor_pkg.sv]
// Purpose: Constants and types shared by the supply reset supervisor.
// Assumes: 100 MHz system clock; timeout figures counted in 1 ms ticks.
// Notes:   Timeout table entries are parameters of the top module.
// Functional notes
// - Serial data receiver always on, open-drain drive
// - Fail output high above trip, low below
// - Monitor B fail output has no delay
// - Reset asserts high while supply is bad
// - Power-up reset held for full timeout
// - Two select bits choose the timeout
// - Timeout 50 to 300 ms, then release
// - Brown-out reset held until supply good plus timeout
// - Manual reset forces reset output high
// - Each fail output captured in status bit
// - Status bits stay set after alarm clears
// - Master reads status over two-wire port
// - After manual reset, hold for full timeout
package supervisor_pkg;

    localparam int          CLK_PERIOD_NS = 10;
    localparam int          TICK_NS       = 1000000;
    localparam int          TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          TICK_WIDTH    = 24;
    localparam int          MS_WIDTH      = 9;

    localparam logic [8:0]  TIMEOUT_MS_0  = 9'h032;
    localparam logic [8:0]  TIMEOUT_MS_1  = 9'h064;
    localparam logic [8:0]  TIMEOUT_MS_2  = 9'h0C8;
    localparam logic [8:0]  TIMEOUT_MS_3  = 9'h12C;

    // Device type 1010, register select 010, read bit 1
    localparam logic [7:0]  STATUS_READ_ADDR = 8'hA5;
    localparam int          STATUS_FAIL_A    = 0;
    localparam int          STATUS_FAIL_B    = 1;
    localparam logic [3:0]  BITS_PER_BYTE    = 4'h8;

    typedef struct packed {
        logic failB;
        logic failA;
    } status_s;

    localparam status_s     STATUS_RESET = '{failB: 1'b0, failA: 1'b0};

    typedef enum logic [2:0] {
        SER_IDLE = 3'b000,
        SER_ADDR = 3'b001,
        SER_LOAD = 3'b010,
        SER_SEND = 3'b011,
        SER_MACK = 3'b100
    } serial_state_e;

endpackage : supervisor_pkg

// [supply_reset_supervisor.sv]
// Purpose: Supply supervisor: timed system reset, two auxiliary monitors with
//          sticky status, and a read-only two-wire status port.
// Assumes: All pin inputs but the timeout selects and statusClear are asynchronous; the serial master is slow
//          compared with clk_sys.
// Notes:   Fail and reset pins are given as logic levels; the board pull-ups
//          turn them into open-drain pins.
`timescale 1ns/100ps
module supply_reset_supervisor #(
    parameter int          TICK_CYCLES  = supervisor_pkg::TICK_CYCLES,
    parameter logic [8:0]  TIMEOUT_MS_0 = supervisor_pkg::TIMEOUT_MS_0,
    parameter logic [8:0]  TIMEOUT_MS_1 = supervisor_pkg::TIMEOUT_MS_1,
    parameter logic [8:0]  TIMEOUT_MS_2 = supervisor_pkg::TIMEOUT_MS_2,
    parameter logic [8:0]  TIMEOUT_MS_3 = supervisor_pkg::TIMEOUT_MS_3
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic                     supplyGood,
    input  wire logic                     manualResetIn,
    input  wire logic                     auxMonitorAInput,
    input  wire logic                     auxMonitorBInput,
    input  wire logic                     timeoutSelectBit0,
    input  wire logic                     timeoutSelectBit1,
    input  wire logic                     statusClear,
    input  wire logic                     sclIn,
    input  wire logic                     sdaIn,
    output logic                          sdaOut,
    output logic                          sdaOe,
    output logic                          systemReset,
    output logic                          auxMonitorAFailOut,
    output logic                          auxMonitorBFailOut,
    output supervisor_pkg::status_s       controlStatusRegister
);
    import supervisor_pkg::*;

    // Two-flop synchronisers for every pin but the timeout selects and statusClear
    logic [5:0] pinMeta;
    logic [5:0] pinSync;
    logic       sclPrev;
    logic       sdaPrev;

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pinMeta <= 6'h00;
            pinSync <= 6'h00;
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
        end
        else
        begin
            pinMeta <= {sdaIn, sclIn, auxMonitorBInput, auxMonitorAInput, manualResetIn, supplyGood};
            pinSync <= pinMeta;
            sclPrev <= pinSync[4];
            sdaPrev <= pinSync[5];
        end
    end

    logic goodSync;
    logic manualSync;
    logic auxASync;
    logic auxBSync;
    logic sclSync;
    logic sdaSync;

    always_comb
    begin
        goodSync   = pinSync[0];
        manualSync = pinSync[1];
        auxASync   = pinSync[2];
        auxBSync   = pinSync[3];
        sclSync    = pinSync[4];
        sdaSync    = pinSync[5];
    end

    // Reset timeout: 1 ms tick divider and millisecond counter
    logic [TICK_WIDTH-1:0] tickCount;
    logic [MS_WIDTH-1:0]   msCount;
    logic                  resetHold;
    logic [TICK_WIDTH-1:0] next_tickCount;
    logic [MS_WIDTH-1:0]   next_msCount;
    logic                  next_systemReset;
    logic [MS_WIDTH-1:0]   timeoutMs;
    logic                  tick;

    always_comb
    begin
        case ({timeoutSelectBit1, timeoutSelectBit0})
            2'b00:   timeoutMs = TIMEOUT_MS_0;
            2'b01:   timeoutMs = TIMEOUT_MS_1;
            2'b10:   timeoutMs = TIMEOUT_MS_2;
            2'b11:   timeoutMs = TIMEOUT_MS_3;
            default: timeoutMs = TIMEOUT_MS_3;
        endcase
        resetHold = !goodSync || manualSync;
        tick = (tickCount == TICK_WIDTH'(TICK_CYCLES - 1));
        next_tickCount   = tickCount;
        next_msCount     = msCount;
        next_systemReset = systemReset;
        if (resetHold)
        begin
            // Any new cause starts the wait over from zero
            next_tickCount   = '0;
            next_msCount     = '0;
            next_systemReset = 1'b1;
        end
        else if (systemReset)
        begin
            next_tickCount = tick ? '0 : tickCount + 1'b1;
            if (tick)
            begin
                next_msCount = msCount + 1'b1;
            end
            // Compare with >= so a select change mid-wait cannot stall release
            if (tick && (msCount + 1'b1 >= timeoutMs))
            begin
                next_systemReset = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            tickCount   <= '0;
            msCount     <= '0;
            systemReset <= 1'b1;
        end
        else
        begin
            tickCount   <= next_tickCount;
            msCount     <= next_msCount;
            systemReset <= next_systemReset;
        end
    end

    // Auxiliary monitors and sticky status
    status_s next_status;

    always_comb
    begin
        next_status = controlStatusRegister;
        if (statusClear)
        begin
            next_status = STATUS_RESET;
        end
        // Setting after the clear lets a same-cycle alarm win
        if (auxASync)
        begin
            next_status.failA = 1'b1;
        end
        if (auxBSync)
        begin
            next_status.failB = 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            auxMonitorAFailOut    <= 1'b0;
            auxMonitorBFailOut    <= 1'b0;
            controlStatusRegister <= STATUS_RESET;
        end
        else
        begin
            auxMonitorAFailOut    <= auxASync;
            auxMonitorBFailOut    <= auxBSync;
            controlStatusRegister <= next_status;
        end
    end

    // Two-wire read-only status port, timed by the master clock
    serial_state_e state;
    serial_state_e next_state;
    logic [3:0]    bitCount;
    logic [7:0]    shiftReg;
    logic [3:0]    next_bitCount;
    logic [7:0]    next_shiftReg;
    logic          next_sdaOe;
    logic          sclRise;
    logic          sclFall;
    logic          startSeen;
    logic          stopSeen;

    always_comb
    begin
        sclRise   = sclSync && !sclPrev;
        sclFall   = !sclSync && sclPrev;
        startSeen = sclSync && sclPrev && sdaPrev && !sdaSync;
        stopSeen  = sclSync && sclPrev && !sdaPrev && sdaSync;
        next_state    = state;
        next_bitCount = bitCount;
        next_shiftReg = shiftReg;
        next_sdaOe    = sdaOe;
        if (startSeen)
        begin
            next_state    = SER_ADDR;
            next_bitCount = 4'h0;
            next_sdaOe    = 1'b0;
        end
        else if (stopSeen)
        begin
            next_state = SER_IDLE;
            next_sdaOe = 1'b0;
        end
        else
        begin
            case (state)
                SER_IDLE:
                begin
                    next_sdaOe = 1'b0;
                end
                SER_ADDR:
                begin
                    if (sclRise && bitCount != BITS_PER_BYTE)
                    begin
                        next_shiftReg = {shiftReg[6:0], sdaSync};
                        next_bitCount = bitCount + 1'b1;
                    end
                    else if (sclFall && bitCount == BITS_PER_BYTE)
                    begin
                        // Other addresses and writes are not acknowledged
                        if (shiftReg == STATUS_READ_ADDR)
                        begin
                            next_sdaOe = 1'b1;
                            next_state = SER_LOAD;
                        end
                        else
                        begin
                            next_state = SER_IDLE;
                        end
                    end
                end
                SER_LOAD:
                begin
                    if (sclFall)
                    begin
                        next_shiftReg = {6'h00, controlStatusRegister};
                        // The top bit must already stand on the pin during the first data clock
                        next_sdaOe    = !next_shiftReg[7];
                        next_bitCount = 4'h1;
                        next_state    = SER_SEND;
                    end
                end
                SER_SEND:
                begin
                    if (sclFall)
                    begin
                        if (bitCount == BITS_PER_BYTE)
                        begin
                            next_sdaOe = 1'b0;
                            next_state = SER_MACK;
                        end
                        else
                        begin
                            next_sdaOe    = !shiftReg[6];
                            next_shiftReg = {shiftReg[6:0], 1'b0};
                            next_bitCount = bitCount + 1'b1;
                        end
                    end
                end
                SER_MACK:
                begin
                    if (sclRise)
                    begin
                        next_state = sdaSync ? SER_IDLE : SER_LOAD;
                    end
                end
                default:
                begin
                    next_state = SER_IDLE;
                    next_sdaOe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state    <= SER_IDLE;
            bitCount <= 4'h0;
            shiftReg <= 8'h00;
            sdaOe    <= 1'b0;
            sdaOut   <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            bitCount <= next_bitCount;
            shiftReg <= next_shiftReg;
            sdaOe    <= next_sdaOe;
            sdaOut   <= 1'b0;
        end
    end

endmodule : supply_reset_supervisor

// [two_wire_master.sv]
// Purpose: Two-wire bus master standing in for the host processor.
// Assumes: Each bus phase lasts nine clk_sys cycles.
// Notes:   Reads one byte, then ends with no-acknowledge and STOP.
`timescale 1ns/100ps
module two_wire_master (
    input  wire logic clk_sys,
    input  wire logic sdaLine,
    output logic      scl = 1'b1,
    output logic      sdaDrv = 1'b1
);
    task automatic phase(input logic c, input logic d);
        @(posedge clk_sys);
        scl <= c;
        sdaDrv <= d;
        repeat (8) @(posedge clk_sys);
    endtask : phase
    // Data moves only while the clock is low, so START and STOP stay unique
    task automatic send_bit(input logic d);
        phase(1'b0, sdaDrv);
        phase(1'b0, d);
        phase(1'b1, d);
    endtask : send_bit
    task automatic read_status(input logic [7:0] addr, output logic ack, output logic [7:0] data);
        phase(1'b1, 1'b0);
        for (int i = 7; i >= 0; i--)
            send_bit(addr[i]);
        send_bit(1'b1);
        ack = !sdaLine;
        for (int i = 7; i >= 0; i--)
        begin
            send_bit(1'b1);
            data[i] = sdaLine;
        end
        send_bit(1'b1);
        phase(1'b0, 1'b1);
        phase(1'b0, 1'b0);
        phase(1'b1, 1'b0);
        phase(1'b1, 1'b1);
    endtask : read_status
endmodule : two_wire_master

// [supervisor_checker.sv]
// Purpose: Port-level assertions for the supply reset supervisor.
// Assumes: Timeout select pins stay steady while a timeout runs.
// Notes:   Windows allow for the three-flop pin latency.
`timescale 1ns/100ps
module supervisor_checker #(
    parameter int         TICK_CYCLES  = 10,
    parameter logic [8:0] TIMEOUT_MS_0 = 9'h002,
    parameter logic [8:0] TIMEOUT_MS_1 = 9'h003,
    parameter logic [8:0] TIMEOUT_MS_2 = 9'h004,
    parameter logic [8:0] TIMEOUT_MS_3 = 9'h005
) (
    input wire logic                    clk_sys,
    input wire logic                    rst,
    input wire logic                    supplyGood,
    input wire logic                    manualResetIn,
    input wire logic                    auxMonitorAInput,
    input wire logic                    auxMonitorBInput,
    input wire logic                    timeoutSelectBit0,
    input wire logic                    timeoutSelectBit1,
    input wire logic                    statusClear,
    input wire logic                    sdaOut,
    input wire logic                    systemReset,
    input wire logic                    auxMonitorAFailOut,
    input wire logic                    auxMonitorBFailOut,
    input wire supervisor_pkg::status_s controlStatusRegister
);
    import supervisor_pkg::*;
    int unsigned quiet;
    int unsigned limit;
    logic [2:0]  since;
    always_comb
    begin
        case ({timeoutSelectBit1, timeoutSelectBit0})
            2'b00:   limit = TIMEOUT_MS_0 * TICK_CYCLES;
            2'b01:   limit = TIMEOUT_MS_1 * TICK_CYCLES;
            2'b10:   limit = TIMEOUT_MS_2 * TICK_CYCLES;
            default: limit = TIMEOUT_MS_3 * TICK_CYCLES;
        endcase
    end
    // Quiet counts pin cycles free of any hold; capped so it never wraps
    always_ff @(posedge clk_sys)
    begin
        if (rst || !supplyGood || manualResetIn)
            quiet <= 32'h0;
        else if (quiet < 32'h7FFFFFFF)
            quiet <= quiet + 32'h1;
        if (rst)
            since <= 3'h0;
        else if (since != 3'h7)
            since <= since + 3'h1;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence a_held;
        controlStatusRegister.failA && !statusClear ##1 !statusClear;
    endsequence
    chk_supply_low_reset: assert property (!supplyGood [*4] |-> systemReset)
        else $error("reset low while supply bad");
    chk_manual_forces: assert property (manualResetIn [*4] |-> systemReset)
        else $error("manual reset ignored");
    chk_release_early: assert property ($fell(systemReset) |-> quiet >= limit - 1)
        else $error("reset released before timeout");
    chk_release_late: assert property (quiet == limit + 8 |-> !systemReset)
        else $error("reset held past timeout");
    chk_fail_a_follows: assert property (since == 3'h7 |-> auxMonitorAFailOut == $past(auxMonitorAInput, 3))
        else $error("fail A not following input");
    chk_fail_b_follows: assert property (since == 3'h7 |-> auxMonitorBFailOut == $past(auxMonitorBInput, 3))
        else $error("fail B not following input");
    chk_status_capture: assert property (({auxMonitorBFailOut, auxMonitorAFailOut} & ~controlStatusRegister) == 2'b00)
        else $error("fail output not captured");
    chk_status_sticky: assert property (a_held |-> controlStatusRegister.failA)
        else $error("status bit dropped");
    chk_sda_open_drain: assert property (sdaOut == 1'b0)
        else $error("data pin driven high");
endmodule : supervisor_checker
bind supply_reset_supervisor supervisor_checker #(
    .TICK_CYCLES(TICK_CYCLES), .TIMEOUT_MS_0(TIMEOUT_MS_0), .TIMEOUT_MS_1(TIMEOUT_MS_1),
    .TIMEOUT_MS_2(TIMEOUT_MS_2), .TIMEOUT_MS_3(TIMEOUT_MS_3)
) supervisor_checker_i (
    .clk_sys, .rst, .supplyGood, .manualResetIn, .auxMonitorAInput, .auxMonitorBInput,
    .timeoutSelectBit0, .timeoutSelectBit1, .statusClear, .sdaOut, .systemReset,
    .auxMonitorAFailOut, .auxMonitorBFailOut, .controlStatusRegister
);

// [tb.sv]
// Purpose: Self-checking bench for the supply reset supervisor.
// Assumes: Small tick and timeout values keep the run short.
// Notes:   SDA is a wired-AND with a pull-up; nobody drives it high.
`timescale 1ns/100ps
module tb;
    import supervisor_pkg::*;
    localparam int         TK    = 10;
    localparam logic [8:0] MS[4] = '{9'h002, 9'h003, 9'h004, 9'h005};
    logic       clk_sys = 1'b0;
    logic       rst = 1'b1;
    logic       supplyGood = 1'b0;
    logic       manualResetIn = 1'b0;
    logic       auxMonitorAInput = 1'b0;
    logic       auxMonitorBInput = 1'b0;
    logic       timeoutSelectBit0 = 1'b0;
    logic       timeoutSelectBit1 = 1'b0;
    logic       statusClear = 1'b0;
    logic       scl, sdaDrv, sdaOut, sdaOe, systemReset, ack;
    logic       auxMonitorAFailOut, auxMonitorBFailOut;
    logic [7:0] rdData;
    status_s    controlStatusRegister;
    wire        sdaLine = sdaDrv & ~sdaOe;
    int         n_mismatch = 0;
    int         n_compared = 0;
    always #5 clk_sys = ~clk_sys;
    supply_reset_supervisor #(
        .TICK_CYCLES(TK), .TIMEOUT_MS_0(MS[0]), .TIMEOUT_MS_1(MS[1]),
        .TIMEOUT_MS_2(MS[2]), .TIMEOUT_MS_3(MS[3])
    ) supply_reset_supervisor_i (
        .clk_sys, .rst, .supplyGood, .manualResetIn, .auxMonitorAInput,
        .auxMonitorBInput, .timeoutSelectBit0, .timeoutSelectBit1, .statusClear,
        .sclIn(scl), .sdaIn(sdaLine), .sdaOut, .sdaOe, .systemReset,
        .auxMonitorAFailOut, .auxMonitorBFailOut, .controlStatusRegister
    );
    two_wire_master two_wire_master_i (.clk_sys, .sdaLine, .scl, .sdaDrv);
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (ok !== 1'b1)
        begin
            n_mismatch++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    // Counts edges from the last hold release until the reset output drops
    task automatic wait_release(input logic [1:0] sel);
        int n;
        n = 0;
        #1;
        while (systemReset !== 1'b0 && n < 400)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check(n >= MS[sel] * TK - 1 && n <= MS[sel] * TK + 8, "reset release time");
        if (n >= 400)
            final_report;
    endtask : wait_release
    task automatic timed_hold(input logic [1:0] sel, input logic brown, input int gap);
        @(posedge clk_sys);
        {timeoutSelectBit1, timeoutSelectBit0} <= sel;
        supplyGood <= !brown;
        manualResetIn <= !brown;
        repeat (6) @(posedge clk_sys);
        supplyGood <= 1'b1;
        manualResetIn <= 1'b0;
        #1 check(systemReset, "hold did not force reset");
        if (gap > 0)
        begin
            repeat (gap) @(posedge clk_sys);
            manualResetIn <= 1'b1;
            repeat (2) @(posedge clk_sys);
            manualResetIn <= 1'b0;
        end
        wait_release(sel);
    endtask : timed_hold
    initial
    begin
        repeat (20) @(posedge clk_sys);
        #1 check(systemReset && controlStatusRegister === STATUS_RESET && !sdaOe, "reset state");
        @(posedge clk_sys);
        rst <= 1'b0;
        supplyGood <= 1'b1;
        wait_release(2'b00);
        for (int s = 0; s < 4; s++)
            timed_hold(s[1:0], s[0], 0);
        timed_hold(2'b11, 1'b0, 25);
        @(posedge clk_sys);
        auxMonitorAInput <= 1'b1;
        auxMonitorBInput <= 1'b1;
        repeat (4) @(posedge clk_sys);
        auxMonitorAInput <= 1'b0;
        #1 check(auxMonitorAFailOut && auxMonitorBFailOut, "fail outputs not high");
        repeat (4) @(posedge clk_sys);
        auxMonitorBInput <= 1'b0;
        #1 check(!auxMonitorAFailOut && auxMonitorBFailOut, "fail A not low");
        repeat (4) @(posedge clk_sys);
        #1 check(controlStatusRegister === 2'b11 && !auxMonitorBFailOut, "status not sticky");
        two_wire_master_i.read_status(8'hA5, ack, rdData);
        check(ack && rdData === 8'h03, "status read");
        two_wire_master_i.read_status(8'hA4, ack, rdData);
        check(!ack && rdData === 8'hFF, "write address answered");
        @(posedge clk_sys);
        statusClear <= 1'b1;
        @(posedge clk_sys);
        statusClear <= 1'b0;
        #1 check(controlStatusRegister === STATUS_RESET, "status not cleared");
        // A live alarm must win over a clear held in the same cycles
        @(posedge clk_sys);
        auxMonitorAInput <= 1'b1;
        statusClear <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1 check(controlStatusRegister === 2'b01, "clear beat live alarm");
        final_report;
    end
endmodule : tb
